// [psc_dev.sv]
`timescale 1ns/1ns
`include "psc_regs.svh"
// Notes on behaviour
// - three-bit fifo mode, resets to bypass
// - five-bit watermark level below mode field
// - reference pressure assembled from three bytes
// - reference pressure is auto-zero/auto-ref baseline
// - plain output is measured minus 256 times offset
// - host may store post-solder offset calibration
// - low-current enable bit 0, resets zero
// - host changes low-current only when powered down
// - low-current setting covers single and continuous
// - host writes zeros to bits 7..2
// - host preserves reserved bit 1 by rmw
// - bit 7 shows reboot phase running
// - bit 2 shows any interrupt event
// - bit 1 shows low differential event
// - bit 0 shows high differential event
// - address auto-increments, enable defaults one
// - soft reset restores control registers, self-clears
module psc_dev (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  psc_if.dev link,
  input wire logic [23:0] measured_press_i,
  input wire logic differential_irq_en_i,
  input wire logic auto_zero_i,
  input wire logic auto_ref_fn_i,
  input wire logic press_low_evt_i,
  input wire logic press_high_evt_i,
  output logic [23:0] pressure_output_o,
  output psc_pkg::psc_fifo_mode_e fifo_mode_o,
  output logic [4:0] watermark_level_o,
  output logic [23:0] ref_pressure_value_o,
  output logic low_current_en_o,
  output logic boot_busy_o
);

  logic [7:0] fifo_ctrl_r, fifo_ctrl_nxt;
  logic [23:0] ref_r, ref_nxt;
  logic [15:0] ofs_r, ofs_nxt;
  logic [7:0] pwr_r, pwr_nxt;
  logic [7:0] ctrl2_r, ctrl2_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic ack_r, ack_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic pl_r, pl_nxt;
  logic ph_r, ph_nxt;
  logic [7:0] boot_cnt_r, boot_cnt_nxt;
  logic [23:0] press_r, press_nxt;

  // decode helpers, all combinational
  logic take;
  logic [7:0] eff_addr;
  logic boot_busy;
  logic rd_int_src;


  // the boot count runs down from reset or a boot command; busy while
  // nonzero, and the same level feeds both status registers
  assign boot_busy = (boot_cnt_r != 8'h00);

  // register file: access decode, sticky event flags, boot timer, soft reset
  // the ack cycle doubles as a guard: req is still high then, so a take
  // there would run the same byte twice
  // the pointer is reloaded on every take, read or write, and steps only while auto-increment is set,
  // so a streamed read after a write continues from the written address plus one
  // soft reset leaves offset and power config alone; they hold calibration
  // and the power choice, which software must not lose on a restart
  always_comb begin
    fifo_ctrl_nxt = fifo_ctrl_r;
    ref_nxt = ref_r;
    ofs_nxt = ofs_r;
    pwr_nxt = pwr_r;
    ctrl2_nxt = ctrl2_r;
    ptr_nxt = ptr_r;
    rdata_nxt = rdata_r;
    boot_cnt_nxt = boot_busy ? boot_cnt_r - 8'h01 : boot_cnt_r;
    rd_int_src = 1'b0;
    // a request is taken once; the ack cycle blocks a second take
    take = link.req & ~ack_r;
    ack_nxt = take;
    eff_addr = link.start ? link.addr : ptr_r;
    if (take) begin
      ptr_nxt = eff_addr + {7'h00, ctrl2_r[`PSC_CTRL2_AUTOINC_BIT]};
      if (link.we) begin
        case (eff_addr)
          `PSC_FIFO_CTRL_ADDR: fifo_ctrl_nxt = link.wdata;
          `PSC_REF_LOW_ADDR: ref_nxt[7:0] = link.wdata;
          `PSC_REF_MID_ADDR: ref_nxt[15:8] = link.wdata;
          `PSC_REF_HIGH_ADDR: ref_nxt[23:16] = link.wdata;
          `PSC_OFS_LOW_ADDR: ofs_nxt[7:0] = link.wdata;
          `PSC_OFS_HIGH_ADDR: ofs_nxt[15:8] = link.wdata;
          `PSC_PWR_CFG_ADDR: pwr_nxt = link.wdata;
          `PSC_CTRL2_ADDR: begin
            // boot and reset bits are commands, never stored
            ctrl2_nxt = link.wdata;
            ctrl2_nxt[`PSC_CTRL2_BOOT_BIT] = 1'b0;
            ctrl2_nxt[`PSC_CTRL2_SWRST_BIT] = 1'b0;
            if (link.wdata[`PSC_CTRL2_BOOT_BIT]) begin
              boot_cnt_nxt = 8'(`PSC_BOOT_CYC);
            end
            if (link.wdata[`PSC_CTRL2_SWRST_BIT]) begin
              fifo_ctrl_nxt = `PSC_FIFO_CTRL_RST;
              ref_nxt = `PSC_REF_RST;
              ctrl2_nxt = `PSC_CTRL2_RST;
            end
          end
          default: ; // interrupt source and unmapped: write ignored
        endcase
      end else begin
        case (eff_addr)
          `PSC_FIFO_CTRL_ADDR: rdata_nxt = fifo_ctrl_r;
          `PSC_REF_LOW_ADDR: rdata_nxt = ref_r[7:0];
          `PSC_REF_MID_ADDR: rdata_nxt = ref_r[15:8];
          `PSC_REF_HIGH_ADDR: rdata_nxt = ref_r[23:16];
          `PSC_OFS_LOW_ADDR: rdata_nxt = ofs_r[7:0];
          `PSC_OFS_HIGH_ADDR: rdata_nxt = ofs_r[15:8];
          `PSC_PWR_CFG_ADDR: rdata_nxt = pwr_r;
          `PSC_CTRL2_ADDR: begin
            rdata_nxt = ctrl2_r;
            rdata_nxt[`PSC_CTRL2_BOOT_BIT] = boot_busy;
          end
          `PSC_INT_SRC_ADDR: begin
            rdata_nxt = 8'h00;
            rdata_nxt[`PSC_INT_BOOT_BIT] = boot_busy;
            rdata_nxt[`PSC_INT_IA_BIT] = pl_r | ph_r;
            rdata_nxt[`PSC_INT_PL_BIT] = pl_r;
            rdata_nxt[`PSC_INT_PH_BIT] = ph_r;
            rd_int_src = 1'b1;
          end
          default: rdata_nxt = 8'h00;
        endcase
      end
    end
    // reading the source clears it, but a same-cycle event still lands
    pl_nxt = press_low_evt_i | (pl_r & ~rd_int_src);
    ph_nxt = press_high_evt_i | (ph_r & ~rd_int_src);
  end

  // register file flops; a new power-up also runs the trimming reload
  // ce_i low freezes every register, including the boot count,
  // so a stalled clock enable stretches the reload in cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fifo_ctrl_r <= `PSC_FIFO_CTRL_RST;
      ref_r <= `PSC_REF_RST;
      ofs_r <= `PSC_OFS_RST;
      pwr_r <= `PSC_PWR_CFG_RST;
      ctrl2_r <= `PSC_CTRL2_RST;
      ptr_r <= 8'h00;
      ack_r <= 1'b0;
      rdata_r <= 8'h00;
      pl_r <= 1'b0;
      ph_r <= 1'b0;
      boot_cnt_r <= 8'(`PSC_BOOT_CYC);
    end else if (ce_i) begin
      fifo_ctrl_r <= fifo_ctrl_nxt;
      ref_r <= ref_nxt;
      ofs_r <= ofs_nxt;
      pwr_r <= pwr_nxt;
      ctrl2_r <= ctrl2_nxt;
      ptr_r <= ptr_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      pl_r <= pl_nxt;
      ph_r <= ph_nxt;
      boot_cnt_r <= boot_cnt_nxt;
    end
  end

  // pressure output path; differential mode leaves the raw value untouched when auto-zero and auto-ref are off
  // the offset is scaled by 256 by placing it above eight zero bits;
  // all subtractions wrap at 24 bits as the output is two's complement
  always_comb begin
    if (auto_zero_i | auto_ref_fn_i) begin
      press_nxt = measured_press_i - ref_r;
    end else if (!differential_irq_en_i) begin
      press_nxt = measured_press_i - {ofs_r, 8'h00};
    end else begin
      press_nxt = measured_press_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      press_r <= 24'h000000;
    end else if (ce_i) begin
      press_r <= press_nxt;
    end
  end

  // link answers and configuration straight from flops
  assign link.ack = ack_r;
  assign link.rdata = rdata_r;
  assign pressure_output_o = press_r;

  // the mode field is cast as is, so the reserved code shows up as its own
  // enum value rather than being folded into bypass
  assign fifo_mode_o = psc_pkg::psc_fifo_mode_e'(fifo_ctrl_r[`PSC_MODE_MSB:`PSC_MODE_LSB]);
  assign watermark_level_o = fifo_ctrl_r[`PSC_WTM_MSB:`PSC_WTM_LSB];
  assign ref_pressure_value_o = ref_r;
  // one level feeds both acquisition modes, so no per-mode copy exists
  assign low_current_en_o = pwr_r[`PSC_PWR_LC_BIT];
  assign boot_busy_o = boot_busy;

endmodule : psc_dev

// [psc_host.sv]
`timescale 1ns/1ns
`include "psc_regs.svh"
// host controller: wishbone command registers drive the sensor link
module psc_host (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic powered_down_i,
  psc_if.host link
);

  psc_pkg::psc_hstate_e st_r, st_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic refused_r, refused_nxt;
  logic wb_ack_r, wb_ack_nxt;
  logic [31:0] wb_dat_r, wb_dat_nxt;
  logic req_r, req_nxt;
  logic start_r, start_nxt;
  logic we_r, we_nxt;
  logic [7:0] laddr_r, laddr_nxt;
  logic [7:0] lwdata_r, lwdata_nxt;
  logic hit;
  logic wr_ctrl;

  // bus slave and transfer sequencer
  always_comb begin
    st_nxt = st_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    refused_nxt = refused_r;
    wb_dat_nxt = wb_dat_r;
    req_nxt = req_r;
    start_nxt = start_r;
    we_nxt = we_r;
    laddr_nxt = laddr_r;
    lwdata_nxt = lwdata_r;
    hit = wb_cyc_i & wb_stb_i & ~wb_ack_r;
    wb_ack_nxt = hit;
    wr_ctrl = 1'b0;
    if (hit & wb_we_i & wb_sel_i[0]) begin
      case (wb_adr_i)
        `PSC_WB_ADDR_OFS: addr_nxt = wb_dat_i[7:0];
        `PSC_WB_WDATA_OFS: wdata_nxt = wb_dat_i[7:0];
        `PSC_WB_CTRL_OFS: wr_ctrl = 1'b1;
        default: ;
      endcase
    end
    if (hit & ~wb_we_i) begin
      case (wb_adr_i)
        `PSC_WB_ADDR_OFS: wb_dat_nxt = {24'h000000, addr_r};
        `PSC_WB_WDATA_OFS: wb_dat_nxt = {24'h000000, wdata_r};
        `PSC_WB_STAT_OFS: begin
          wb_dat_nxt = 32'h00000000;
          wb_dat_nxt[`PSC_WB_RDATA_LSB +: 8] = rdata_r;
          wb_dat_nxt[`PSC_WB_REFUSED_BIT] = refused_r;
          wb_dat_nxt[`PSC_WB_BUSY_BIT] = (st_r != psc_pkg::psc_h_idle);
        end
        default: wb_dat_nxt = 32'h00000000;
      endcase
    end
    case (st_r)
      psc_pkg::psc_h_idle: begin
        if (wr_ctrl & wb_dat_i[`PSC_WB_GO_WR_BIT]) begin
          // writes always carry their address so the target is known here
          start_nxt = 1'b1;
          laddr_nxt = addr_r;
          if (addr_r == `PSC_PWR_CFG_ADDR) begin
            if (!powered_down_i) begin
              refused_nxt = 1'b1;
            end else begin
              refused_nxt = 1'b0;
              req_nxt = 1'b1;
              we_nxt = 1'b0;
              st_nxt = psc_pkg::psc_h_rmw;
            end
          end else begin
            refused_nxt = 1'b0;
            req_nxt = 1'b1;
            we_nxt = 1'b1;
            lwdata_nxt = wdata_r;
            st_nxt = psc_pkg::psc_h_wr;
          end
        end else if (wr_ctrl & wb_dat_i[`PSC_WB_GO_RD_BIT]) begin
          refused_nxt = 1'b0;
          req_nxt = 1'b1;
          we_nxt = 1'b0;
          start_nxt = ~wb_dat_i[`PSC_WB_CONT_BIT];
          laddr_nxt = addr_r;
          st_nxt = psc_pkg::psc_h_rd;
        end
      end
      psc_pkg::psc_h_rmw: begin
        if (link.ack) begin
          // keep reserved bit, force upper bits to zero
          lwdata_nxt = 8'h00;
          lwdata_nxt[`PSC_PWR_RSVD_BIT] = link.rdata[`PSC_PWR_RSVD_BIT];
          lwdata_nxt[`PSC_PWR_LC_BIT] = wdata_r[`PSC_PWR_LC_BIT];
          we_nxt = 1'b1;
          st_nxt = psc_pkg::psc_h_wr;
        end
      end
      psc_pkg::psc_h_wr: begin
        if (link.ack) begin
          req_nxt = 1'b0;
          st_nxt = psc_pkg::psc_h_idle;
        end
      end
      psc_pkg::psc_h_rd: begin
        if (link.ack) begin
          req_nxt = 1'b0;
          rdata_nxt = link.rdata;
          st_nxt = psc_pkg::psc_h_idle;
        end
      end
      default: begin
        req_nxt = 1'b0;
        st_nxt = psc_pkg::psc_h_idle;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= psc_pkg::psc_h_idle;
      addr_r <= 8'h00;
      wdata_r <= 8'h00;
      rdata_r <= 8'h00;
      refused_r <= 1'b0;
      wb_ack_r <= 1'b0;
      wb_dat_r <= 32'h00000000;
      req_r <= 1'b0;
      start_r <= 1'b0;
      we_r <= 1'b0;
      laddr_r <= 8'h00;
      lwdata_r <= 8'h00;
    end else if (ce_i) begin
      st_r <= st_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      refused_r <= refused_nxt;
      wb_ack_r <= wb_ack_nxt;
      wb_dat_r <= wb_dat_nxt;
      req_r <= req_nxt;
      start_r <= start_nxt;
      we_r <= we_nxt;
      laddr_r <= laddr_nxt;
      lwdata_r <= lwdata_nxt;
    end
  end

  assign wb_ack_o = wb_ack_r;
  assign wb_dat_o = wb_dat_r;
  assign link.req = req_r;
  assign link.start = start_r;
  assign link.we = we_r;
  assign link.addr = laddr_r;
  assign link.wdata = lwdata_r;

endmodule : psc_host

// [psc_if.sv]
`timescale 1ns/1ns
// register link between host controller and sensor register bank
interface psc_if;
  logic req;
  logic start;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;

  modport dev (input req, input start, input we, input addr, input wdata,
    output ack, output rdata);
  modport host (output req, output start, output we, output addr, output wdata,
    input ack, input rdata);
endinterface : psc_if

// [psc_link_sva.sv]
`timescale 1ns/1ns
// watches the sensor link between host controller and register bank
module psc_link_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req,
  input wire logic start,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic take;
  logic rd_pwr_r;
  logic rd_pwr_nxt;
  logic bit1_r;
  logic bit1_nxt;
  logic seen_r;
  logic seen_nxt;
  assign take = req && !ack;
  // keep the reserved bit last read back, since the host must never alter it
  always_comb begin
    rd_pwr_nxt = rd_pwr_r;
    bit1_nxt = bit1_r;
    seen_nxt = seen_r;
    if (take) begin
      rd_pwr_nxt = !we && start && addr == 8'h1A;
    end
    if (ack && rd_pwr_r) begin
      bit1_nxt = rdata[1];
      seen_nxt = 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_pwr_r <= 1'b0;
      bit1_r <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      rd_pwr_r <= rd_pwr_nxt;
      bit1_r <= bit1_nxt;
      seen_r <= seen_nxt;
    end
  end
  AST_ACK_NEXT: assert property (take |=> ack)
    else $error("link request not acknowledged next cycle");
  AST_ACK_PULSE: assert property (ack |=> !ack)
    else $error("link ack longer than one cycle");
  AST_ACK_CAUSE: assert property (ack |-> $past(take))
    else $error("link ack without request");
  AST_REQ_HOLD: assert property (take |=> req && $stable(addr) && $stable(we)
    && $stable(wdata) && $stable(start))
    else $error("link request changed before ack");
  AST_RDATA_HOLD: assert property (!$stable(rdata) |-> ack && !we)
    else $error("read byte changed outside a read ack");
  AST_INT_ZERO: assert property (take && !we && start && addr == 8'h25
    |=> rdata[6:3] == 4'h0)
    else $error("interrupt source middle bits not zero");
  AST_PWR_ZERO: assert property (req && we && addr == 8'h1A |-> wdata[7:2] == 6'h00)
    else $error("power config upper bits written nonzero");
  AST_PWR_KEEP: assert property (req && we && start && addr == 8'h1A
    |-> seen_r && wdata[1] == bit1_r)
    else $error("power config reserved bit altered");
  CV_INT_READ: cover property (take && !we && addr == 8'h25);
  CV_PWR_WRITE: cover property (take && we && addr == 8'h1A);
  CV_PTR_READ: cover property (take && !we && !start);
endmodule : psc_link_sva

// [psc_pkg.sv]
package psc_pkg;

  typedef enum logic [2:0] {
    psc_fm_bypass = 3'h0,
    psc_fm_fifo = 3'h1,
    psc_fm_stream = 3'h2,
    psc_fm_stream_to_fifo = 3'h3,
    psc_fm_bypass_to_stream = 3'h4,
    psc_fm_reserved = 3'h5,
    psc_fm_dynamic_stream = 3'h6,
    psc_fm_bypass_to_fifo = 3'h7
  } psc_fifo_mode_e;

  typedef enum logic [3:0] {
    psc_h_idle = 4'b0001,
    psc_h_rd = 4'b0010,
    psc_h_rmw = 4'b0100,
    psc_h_wr = 4'b1000
  } psc_hstate_e;

endpackage : psc_pkg

// [psc_regs.svh]
`ifndef PSC_REGS_SVH
`define PSC_REGS_SVH

// sensor register map, byte addresses on the link
`define PSC_CTRL2_ADDR 8'h11
`define PSC_FIFO_CTRL_ADDR 8'h14
`define PSC_REF_LOW_ADDR 8'h15
`define PSC_REF_MID_ADDR 8'h16
`define PSC_REF_HIGH_ADDR 8'h17
`define PSC_OFS_LOW_ADDR 8'h18
`define PSC_OFS_HIGH_ADDR 8'h19
`define PSC_PWR_CFG_ADDR 8'h1A
`define PSC_INT_SRC_ADDR 8'h25

// reset values
`define PSC_FIFO_CTRL_RST 8'h00
`define PSC_CTRL2_RST 8'h10
`define PSC_PWR_CFG_RST 8'h00
`define PSC_REF_RST 24'h000000
`define PSC_OFS_RST 16'h0000

// field positions
`define PSC_WTM_MSB 4
`define PSC_WTM_LSB 0
`define PSC_MODE_MSB 7
`define PSC_MODE_LSB 5
`define PSC_CTRL2_BOOT_BIT 7
`define PSC_CTRL2_AUTOINC_BIT 4
`define PSC_CTRL2_SWRST_BIT 2
`define PSC_PWR_LC_BIT 0
`define PSC_PWR_RSVD_BIT 1
`define PSC_INT_BOOT_BIT 7
`define PSC_INT_IA_BIT 2
`define PSC_INT_PL_BIT 1
`define PSC_INT_PH_BIT 0

// trimming reload time
`define PSC_CLK_NS 10
`define PSC_BOOT_NS 2000
`define PSC_BOOT_CYC ((`PSC_BOOT_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS)

// host controller wishbone offsets and fields
`define PSC_WB_ADDR_OFS 4'h0
`define PSC_WB_WDATA_OFS 4'h4
`define PSC_WB_CTRL_OFS 4'h8
`define PSC_WB_STAT_OFS 4'hC
`define PSC_WB_GO_WR_BIT 0
`define PSC_WB_GO_RD_BIT 1
`define PSC_WB_CONT_BIT 2
`define PSC_WB_BUSY_BIT 0
`define PSC_WB_REFUSED_BIT 1
`define PSC_WB_RDATA_LSB 8

`endif

// [testbench.sv]
`timescale 1ns/1ns
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic wwe = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic wb_ack;
  logic pdn = 1'b0;
  logic ce = 1'b1;
  logic [23:0] meas = 24'h0;
  logic dif = 1'b0;
  logic az = 1'b0;
  logic ar = 1'b0;
  logic lo = 1'b0;
  logic hi = 1'b0;
  logic [23:0] pout;
  psc_pkg::psc_fifo_mode_e fmode;
  logic [4:0] watermark_level;
  logic [23:0] refv;
  logic lc;
  logic boot;
  logic [31:0] st;
  int mismatches = 0;
  int total_checks = 0;
  always #5 clk_i = ~clk_i;
  psc_if i_psc_if ();
  psc_host i_psc_host (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(wwe), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(wb_ack), .powered_down_i(pdn), .link(i_psc_if.host));
  psc_dev i_psc_dev (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .link(i_psc_if.dev),
    .measured_press_i(meas), .differential_irq_en_i(dif), .auto_zero_i(az),
    .auto_ref_fn_i(ar), .press_low_evt_i(lo), .press_high_evt_i(hi),
    .pressure_output_o(pout), .fifo_mode_o(fmode), .watermark_level_o(watermark_level),
    .ref_pressure_value_o(refv), .low_current_en_o(lc), .boot_busy_o(boot));
  psc_link_sva i_psc_link_sva (.clk_i(clk_i), .rst_i(rst_i), .req(i_psc_if.req),
    .start(i_psc_if.start), .we(i_psc_if.we), .addr(i_psc_if.addr),
    .wdata(i_psc_if.wdata), .ack(i_psc_if.ack), .rdata(i_psc_if.rdata));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // one classic cycle, held until the slave acknowledges
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    wwe <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    st = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // load address and data, issue the command, poll until the link is idle
  task automatic cmd(input logic [7:0] a, input logic [7:0] d, input logic [31:0] c);
    wb(4'h0, 1'b1, {24'h0, a});
    wb(4'h4, 1'b1, {24'h0, d});
    wb(4'h8, 1'b1, c);
    do wb(4'hC, 1'b0, 32'h0); while (st[0] !== 1'b0);
  endtask : cmd
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [31:0] c = 32'h2);
    cmd(a, 8'h00, c);
    chk($sformatf("reg %h", a), {24'h0, e}, {24'h0, st[15:8]});
  endtask : rd
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  // bounded run: a hung handshake ends here
  initial begin
    repeat (30000) @(posedge clk_i);
    mismatches++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h25, 8'h80);
    chk("boot", 32'h1, {31'h0, boot});
    for (int a = 8'h14; a <= 8'h1A; a++) rd(8'(a), 8'h00);
    while (boot !== 1'b0) @(posedge clk_i);
    rd(8'h25, 8'h00);
    $display("test reset values done");
    for (int m = 0; m < 8; m++) begin
      cmd(8'h14, {3'(m), 5'h1F - 5'(m)}, 32'h1);
      chk("mode", 32'(m), 32'(fmode));
      chk("wtm", 32'h1F - 32'(m), 32'(watermark_level));
      rd(8'h14, {3'(m), 5'h1F - 5'(m)});
    end
    $display("test fifo control done");
    cmd(8'h15, 8'h56, 32'h1);
    cmd(8'h16, 8'h34, 32'h1);
    cmd(8'h17, 8'h92, 32'h1);
    chk("ref", 32'h923456, {8'h0, refv});
    rd(8'h15, 8'h56);
    rd(8'h16, 8'h34, 32'h6);
    rd(8'h17, 8'h92, 32'h6);
    cmd(8'h18, 8'h02, 32'h1);
    cmd(8'h19, 8'h01, 32'h1);
    meas <= 24'h123456;
    repeat (2) @(posedge clk_i);
    chk("pout", 32'h113256, {8'h0, pout});
    az <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("pout az", 32'h800000, {8'h0, pout});
    az <= 1'b0;
    ar <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("pout ar", 32'h800000, {8'h0, pout});
    ar <= 1'b0;
    dif <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("pout dif", 32'h123456, {8'h0, pout});
    // clock enable low must freeze the output register while the link is idle
    ce <= 1'b0;
    meas <= 24'h000123;
    repeat (3) @(posedge clk_i);
    chk("pout frozen", 32'h123456, {8'h0, pout});
    ce <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("pout thawed", 32'h000123, {8'h0, pout});
    $display("test pressure path done");
    cmd(8'h1A, 8'h01, 32'h1);
    chk("refused", 32'h1, {31'h0, st[1]});
    chk("lc off", 32'h0, {31'h0, lc});
    pdn <= 1'b1;
    cmd(8'h1A, 8'h01, 32'h1);
    chk("lc on", 32'h1, {31'h0, lc});
    rd(8'h1A, 8'h01);
    $display("test low current done");
    cmd(8'h25, 8'hFF, 32'h1);
    rd(8'h25, 8'h00);
    for (int i = 1; i < 4; i++) begin
      {lo, hi} <= 2'(i);
      @(posedge clk_i);
      {lo, hi} <= 2'b00;
      rd(8'h25, 8'h04 | 8'(i));
      rd(8'h25, 8'h00);
    end
    rd(8'h30, 8'h00);
    $display("test interrupt source done");
    cmd(8'h11, 8'h14, 32'h1);
    chk("mode swrst", 32'h0, 32'(fmode));
    chk("ref swrst", 32'h0, {8'h0, refv});
    rd(8'h11, 8'h10);
    rd(8'h18, 8'h02);
    $display("test soft reset done");
    finish_test();
  end
endmodule : testbench
